// [dual_timer_interrupt_unit.sv]
// Dual reload timers, five-source interrupt unit, clock setup and power-down
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "tmr_params.svh"
// Summary of operation
// - Each timer: 8-bit counter plus reload register.
// - Software writes and reads back both reload values.
// - Timer one counts fast oscillator, two slow.
// - Five interrupt sources feed the request register.
// - Each source has request bit and mask bit.
// - Port 0 bit 0 requests on rising edge only.
// - PWM period completion sets its request bit.
// - Any GPIO pin activity wakes from power-down.
// - Power-down output high only while powered down.
// - Static core: all state holds across clock stops.
// - Undivided, one wait: RAM one, external two clocks.
// - Clock source, divider and wait states programmable.
module dual_timer_interrupt_unit (
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic        hf_osc_i,
  input  wire logic        lf_osc_i,
  input  wire logic [7:0]  port0_pins_i,
  input  wire logic [7:0]  port1_pins_i,
  input  wire logic        reserved_evt_i,
  input  wire logic        pwm_period_done_i,
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  output logic             irq_o,
  output logic             powered_down_out_o,
  output logic             cpu_tick_o,
  output logic [3:0]       ext_cycle_clks_o
);
  import tmr_types_pkg::*;
  // Word match of a byte address against a register offset
  function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
    hit = (a[`ADDR_W-1:2] == off[`ADDR_W-1:2]);
  endfunction
  logic [`PIN_W-1:0] pin_rise, pin_chg;     // Synchronised edges
  logic              hf_tick, lf_tick;      // Oscillator count pulses
  logic              p00_rise, gpio_chg;    // Port events
  byte_t             t1_count, t2_count;    // Live counter values
  logic              t1_ovf, t2_ovf;        // Overflow pulses
  irq_vec_t          evt, w1c;              // Set and clear vectors
  logic              pd_set;                // Software asks for power-down
  logic              do_wr;                 // Write performed this cycle
  logic              aw_have_reg, aw_have_next; // Write address held
  logic [11:0]       aw_addr_reg, aw_addr_next;
  logic              w_have_reg, w_have_next;   // Write data held
  byte_t             w_data_reg, w_data_next;
  logic              w_lane_reg, w_lane_next;   // Byte lane 0 enabled
  logic              awrdy_next, wrdy_next, arrdy_next;
  logic              bvalid_next, rvalid_next;
  logic [1:0]        bresp_next, rresp_next;
  logic [31:0]       rdata_next;
  byte_t             t1_reload_reg, t1_reload_next; // Timer one reload
  byte_t             t2_reload_reg, t2_reload_next; // Timer two reload
  irq_vec_t          req_reg, req_next;     // Sticky request bits
  irq_vec_t          mask_reg, mask_next;   // Interrupt enables
  logic              irq_next;
  logic              pd_reg, pd_next;       // Powered-down state
  clk_src_e          src_reg, src_next;     // Processor clock source
  logic [2:0]        div_reg, div_next;     // Divide by value plus one
  logic [1:0]        ws_reg, ws_next;       // Wait states
  logic [2:0]        dcnt_reg, dcnt_next;   // Divider count
  logic              src_tick, ctick_next;
  logic [3:0]        ext_next;
  // All external pins pass the three-stage filter
  pin_sync #(.WIDTH(`PIN_W)) u_sync (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .pins_i   ({port1_pins_i, port0_pins_i, lf_osc_i, hf_osc_i}),
    .rise_o   (pin_rise),
    .chg_o    (pin_chg)
  );
  assign hf_tick  = pin_rise[`SYNC_HF];
  assign lf_tick  = pin_rise[`SYNC_LF];
  assign p00_rise = pin_rise[`SYNC_P0];
  assign gpio_chg = |pin_chg[`PIN_W-1:`SYNC_P0];
  // One timer per oscillator
  reload_timer u_t1 (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .tick_i   (hf_tick),
    .reload_i (t1_reload_reg),
    .count_o  (t1_count),
    .ovf_o    (t1_ovf)
  );
  reload_timer u_t2 (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .tick_i   (lf_tick),
    .reload_i (t2_reload_reg),
    .count_o  (t2_count),
    .ovf_o    (t2_ovf)
  );
  // Bus slave, register file, interrupts and power state
  always_comb begin
    aw_have_next   = aw_have_reg;
    aw_addr_next   = aw_addr_reg;
    w_have_next    = w_have_reg;
    w_data_next    = w_data_reg;
    w_lane_next    = w_lane_reg;
    bvalid_next    = s_axi_bvalid_o;
    bresp_next     = s_axi_bresp_o;
    rvalid_next    = s_axi_rvalid_o;
    rresp_next     = s_axi_rresp_o;
    rdata_next     = s_axi_rdata_o;
    t1_reload_next = t1_reload_reg;
    t2_reload_next = t2_reload_reg;
    mask_next      = mask_reg;
    src_next       = src_reg;
    div_next       = div_reg;
    ws_next        = ws_reg;
    w1c            = '0;
    pd_set         = 1'b0;
    evt            = '0;
    evt[`IRQ_P00]  = p00_rise;
    evt[`IRQ_T1]   = t1_ovf;
    evt[`IRQ_T2]   = t2_ovf;
    evt[`IRQ_RSVD] = reserved_evt_i;
    evt[`IRQ_PWM]  = pwm_period_done_i;
    // Address and data are taken independently, in either order
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata_i[7:0];
      w_lane_next = s_axi_wstrb_i[0];
    end
    if (s_axi_bvalid_o && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    do_wr = aw_have_reg && w_have_reg && !s_axi_bvalid_o;
    if (do_wr) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (|aw_addr_reg[`ADDR_W-1:5]) ? `RESP_SLVERR : `RESP_OKAY;
      // Registers are one byte wide, so only lane 0 stores
      if (w_lane_reg) begin
        if (hit(aw_addr_reg, `OFF_T1_RELOAD)) begin
          t1_reload_next = w_data_reg;
        end else if (hit(aw_addr_reg, `OFF_T2_RELOAD)) begin
          t2_reload_next = w_data_reg;
        end else if (hit(aw_addr_reg, `OFF_IRQ_REQ)) begin
          w1c = w_data_reg[`IRQ_N-1:0];
        end else if (hit(aw_addr_reg, `OFF_IRQ_MASK)) begin
          mask_next = w_data_reg[`IRQ_N-1:0];
        end else if (hit(aw_addr_reg, `OFF_CLK_CFG)) begin
          src_next = clk_src_e'(w_data_reg[`CFG_SRC_BIT]);
          div_next = w_data_reg[`CFG_DIV_MSB:`CFG_DIV_LSB];
          ws_next  = w_data_reg[`CFG_WS_MSB:`CFG_WS_LSB];
        end else if (hit(aw_addr_reg, `OFF_PWR)) begin
          pd_set = w_data_reg[`PWR_DOWN_BIT];
        end
        // Counter words are read-only; writes there are accepted and dropped
      end
    end
    awrdy_next = !aw_have_next;
    wrdy_next  = !w_have_next;
    // Read path: one outstanding read, answered the next cycle
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_next = 1'b1;
      rresp_next  = `RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      if (|s_axi_araddr_i[`ADDR_W-1:5]) begin
        rresp_next = `RESP_SLVERR;
      end else if (hit(s_axi_araddr_i, `OFF_T1_RELOAD)) begin
        rdata_next[7:0] = t1_reload_reg;
      end else if (hit(s_axi_araddr_i, `OFF_T2_RELOAD)) begin
        rdata_next[7:0] = t2_reload_reg;
      end else if (hit(s_axi_araddr_i, `OFF_T1_COUNT)) begin
        rdata_next[7:0] = t1_count;
      end else if (hit(s_axi_araddr_i, `OFF_T2_COUNT)) begin
        rdata_next[7:0] = t2_count;
      end else if (hit(s_axi_araddr_i, `OFF_IRQ_REQ)) begin
        rdata_next[`IRQ_N-1:0] = req_reg;
      end else if (hit(s_axi_araddr_i, `OFF_IRQ_MASK)) begin
        rdata_next[`IRQ_N-1:0] = mask_reg;
      end else if (hit(s_axi_araddr_i, `OFF_CLK_CFG)) begin
        rdata_next[`CFG_WS_MSB:0] = {ws_reg, div_reg, src_reg};
      end else begin
        rdata_next[`PWR_DOWN_BIT] = pd_reg;
      end
    end
    arrdy_next = !rvalid_next;
    // Set beats clear so an event in the clearing cycle survives
    req_next = (req_reg & ~w1c) | evt;
    irq_next = |(req_next & mask_next);
    // Wake applies only when already powered down, and there it wins over a power-down request
    if (pd_reg && gpio_chg) begin
      pd_next = 1'b0;
    end else if (pd_set) begin
      pd_next = 1'b1;
    end else begin
      pd_next = pd_reg;
    end
  end
  // Registers of the bus and control group
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_have_reg        <= 1'b0;
      aw_addr_reg        <= 12'h000;
      w_have_reg         <= 1'b0;
      w_data_reg         <= 8'h00;
      w_lane_reg         <= 1'b0;
      s_axi_awready_o    <= 1'b1;
      s_axi_wready_o     <= 1'b1;
      s_axi_bvalid_o     <= 1'b0;
      s_axi_bresp_o      <= `RESP_OKAY;
      s_axi_arready_o    <= 1'b1;
      s_axi_rvalid_o     <= 1'b0;
      s_axi_rresp_o      <= `RESP_OKAY;
      s_axi_rdata_o      <= 32'h0000_0000;
      t1_reload_reg      <= `RST_RELOAD;
      t2_reload_reg      <= `RST_RELOAD;
      req_reg            <= '0;
      mask_reg           <= `RST_MASK;
      irq_o              <= 1'b0;
      pd_reg             <= 1'b0;
      powered_down_out_o <= 1'b0;
      src_reg            <= SRC_HF;
      div_reg            <= `RST_DIV;
      ws_reg             <= `RST_WS;
    end else begin
      aw_have_reg        <= aw_have_next;
      aw_addr_reg        <= aw_addr_next;
      w_have_reg         <= w_have_next;
      w_data_reg         <= w_data_next;
      w_lane_reg         <= w_lane_next;
      s_axi_awready_o    <= awrdy_next;
      s_axi_wready_o     <= wrdy_next;
      s_axi_bvalid_o     <= bvalid_next;
      s_axi_bresp_o      <= bresp_next;
      s_axi_arready_o    <= arrdy_next;
      s_axi_rvalid_o     <= rvalid_next;
      s_axi_rresp_o      <= rresp_next;
      s_axi_rdata_o      <= rdata_next;
      t1_reload_reg      <= t1_reload_next;
      t2_reload_reg      <= t2_reload_next;
      req_reg            <= req_next;
      mask_reg           <= mask_next;
      irq_o              <= irq_next;
      pd_reg             <= pd_next;
      powered_down_out_o <= pd_next;
      src_reg            <= src_next;
      div_reg            <= div_next;
      ws_reg             <= ws_next;
    end
  end
  // Processor clock: chosen source, divided, stopped while powered down
  always_comb begin
    src_tick   = 1'b0;
    unique case (src_reg)
      SRC_HF: src_tick = hf_tick;
      SRC_LF: src_tick = lf_tick;
    endcase
    ctick_next = 1'b0;
    dcnt_next  = dcnt_reg;
    // Stopping ticks freezes the core without touching its state
    if (!pd_reg && src_tick) begin
      if (dcnt_reg >= div_reg) begin
        dcnt_next  = 3'h0;
        ctick_next = 1'b1;
      end else begin
        dcnt_next = dcnt_reg + 3'h1;
      end
    end
    // Internal RAM takes one clock; each wait state adds one elsewhere
    ext_next = `RAM_CYCLE_CLKS + {2'h0, ws_reg};
  end
  // Registers of the clock group
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dcnt_reg         <= 3'h0;
      cpu_tick_o       <= 1'b0;
      ext_cycle_clks_o <= `RAM_CYCLE_CLKS + {2'h0, `RST_WS};
    end else begin
      dcnt_reg         <= dcnt_next;
      cpu_tick_o       <= ctick_next;
      ext_cycle_clks_o <= ext_next;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_pd_write;
    do_wr && w_lane_reg && hit(aw_addr_reg, `OFF_PWR) && w_data_reg[0] && !gpio_chg;
  endsequence
  a_irq_gate: assert property (irq_o == |(req_reg & mask_reg))
    else $error("interrupt output disagrees with masked requests");
  a_req_sticky: assert property (req_reg[`IRQ_T2] && !w1c[`IRQ_T2] |=> req_reg[`IRQ_T2])
    else $error("request bit dropped without a clear");
  a_p00_edge: assert property (p00_rise |=> req_reg[`IRQ_P00])
    else $error("port edge did not set its request");
  a_pwm_request: assert property (pwm_period_done_i ##1 1'b1 |-> req_reg[`IRQ_PWM])
    else $error("pwm period did not set its request");
  a_t1_reload: assert property (u_t1.tick_i && t1_count == 8'hff |=> t1_count == $past(t1_reload_reg) && t1_ovf)
    else $error("timer one did not reload on overflow");
  a_t1_ovf_req: assert property (t1_ovf |=> req_reg[`IRQ_T1])
    else $error("timer overflow did not set its request");
  a_pd_entry: assert property (s_pd_write |=> powered_down_out_o ##0 pd_reg)
    else $error("power-down write not shown on output");
  a_pd_wake: assert property (pd_reg && gpio_chg |=> !powered_down_out_o)
    else $error("pin activity did not wake the device");
  a_reload_read: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == `OFF_T2_RELOAD
                                  |=> s_axi_rvalid_o && s_axi_rdata_o[7:0] == $past(t2_reload_reg))
    else $error("reload read-back mismatch");
  a_no_tick_pd: assert property (pd_reg |=> !cpu_tick_o)
    else $error("processor tick while powered down");
endmodule

// [tmr_params.svh]
// Offsets, field positions, reset values and counts for the timer and interrupt block
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH
`define ADDR_W         12
`define OFF_T1_RELOAD  12'h000
`define OFF_T2_RELOAD  12'h004
`define OFF_T1_COUNT   12'h008
`define OFF_T2_COUNT   12'h00c
`define OFF_IRQ_REQ    12'h010
`define OFF_IRQ_MASK   12'h014
`define OFF_CLK_CFG    12'h018
`define OFF_PWR        12'h01c
`define IRQ_N          5
`define IRQ_P00        0
`define IRQ_T1         1
`define IRQ_T2         2
`define IRQ_RSVD       3
`define IRQ_PWM        4
`define CFG_SRC_BIT    0
`define CFG_DIV_LSB    1
`define CFG_DIV_MSB    3
`define CFG_WS_LSB     4
`define CFG_WS_MSB     5
`define PWR_DOWN_BIT   0
`define RST_RELOAD     8'h00
`define RST_MASK       5'h00
`define RST_DIV        3'h0
`define RST_WS         2'h1
`define RAM_CYCLE_CLKS 4'h1
`define TMR_TOP        8'hff
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define PIN_W          18
`define SYNC_HF        0
`define SYNC_LF        1
`define SYNC_P0        2
`define SYNC_SETTLE    3'h4
`endif

// [tmr_types_pkg.sv]
// Shared types for the timer and interrupt block
package tmr_types_pkg;
  typedef logic [7:0] byte_t;                // Timer and reload width
  typedef logic [4:0] irq_vec_t;             // One bit per interrupt source
  typedef enum logic {SRC_HF, SRC_LF} clk_src_e; // Processor clock source
endpackage

// [pin_sync.sv]
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
`include "tmr_params.svh"
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] pins_i,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] chg_o
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg;  // Sync chain; s1 feeds only s2
  logic [WIDTH-1:0] lvl_reg, lvl_next;       // Accepted pin level
  logic [WIDTH-1:0] rise_next, chg_next;     // Edge pulses
  logic [2:0]       settle_reg, settle_next; // Blocks edges until chain is filled
  logic             armed;

  // Level moves only where stages two and three agree
  always_comb begin
    armed       = (settle_reg == `SYNC_SETTLE);
    lvl_next    = (s2_reg & s3_reg) | (lvl_reg & (s2_reg ^ s3_reg));
    rise_next   = armed ? (lvl_next & ~lvl_reg) : '0;
    chg_next    = armed ? (lvl_next ^ lvl_reg) : '0;
    settle_next = armed ? settle_reg : settle_reg + 3'h1;
  end

  // Registers only; a pin already high at reset gives no edge
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_reg     <= '0;
      s2_reg     <= '0;
      s3_reg     <= '0;
      lvl_reg    <= '0;
      rise_o     <= '0;
      chg_o      <= '0;
      settle_reg <= 3'h0;
    end else begin
      s1_reg     <= pins_i;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      lvl_reg    <= lvl_next;
      rise_o     <= rise_next;
      chg_o      <= chg_next;
      settle_reg <= settle_next;
    end
  end
endmodule

// [reload_timer.sv]
// Eight-bit up-counter that reloads from a reload value on overflow
`timescale 1ns/1ns
`include "tmr_params.svh"
module reload_timer (
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  input  wire logic       tick_i,
  input  wire logic [7:0] reload_i,
  output logic      [7:0] count_o,
  output logic            ovf_o
);
  logic [7:0] count_next; // Next count
  logic       ovf_next;   // One-cycle overflow pulse

  // Count each tick; passing all-ones reloads and flags overflow
  always_comb begin
    count_next = count_o;
    ovf_next   = 1'b0;
    if (tick_i) begin
      if (count_o == `TMR_TOP) begin
        count_next = reload_i;
        ovf_next   = 1'b1;
      end else begin
        count_next = count_o + 8'h01;
      end
    end
  end

  // The count only changes on a tick, so a stopped source simply holds
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_o <= 8'h00;
      ovf_o   <= 1'b0;
    end else begin
      count_o <= count_next;
      ovf_o   <= ovf_next;
    end
  end
endmodule

// [pin_partner.sv]
// Model of the oscillators and port pins that feed the timer block
`timescale 1ns/1ns
module pin_partner (
  input  wire logic       clock_i,
  output logic            hf_osc_o,
  output logic            lf_osc_o,
  output logic [7:0]      port0_o,
  output logic [7:0]      port1_o
);
  // Everything idle and low at time zero
  initial begin
    hf_osc_o = 1'b0;
    lf_osc_o = 1'b0;
    port0_o  = 8'h00;
    port1_o  = 8'h00;
  end
  // One source per timer; slow half periods outlast the pin filter
  task automatic osc_ticks(input int sel, input int n);
    repeat (n) begin
      if (sel == 0) hf_osc_o <= 1'b1;
      else lf_osc_o <= 1'b1;
      repeat (4) @(posedge clock_i);
      hf_osc_o <= 1'b0;
      lf_osc_o <= 1'b0;
      repeat (4) @(posedge clock_i);
    end
  endtask
  // Any change is a wake event; a port 0 bit 0 rise is an interrupt event
  task automatic set_ports(input logic [7:0] p0, input logic [7:0] p1);
    port0_o <= p0;
    port1_o <= p1;
    @(posedge clock_i);
  endtask
endmodule

// [tb_dual_timer_interrupt_unit.sv]
// Self-checking bench for the dual timer and interrupt block
`timescale 1ns/1ns
`include "tmr_params.svh"
module tb_dual_timer_interrupt_unit;
  import tmr_types_pkg::*;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
  logic        clock_i, arst_n_i, rsv, pwm;  // Clock, reset, same-clock events
  logic        hf, lf, irq, powered_down_out, tick;       // Pin side and outputs
  logic [7:0]  p0, p1;                       // Port pins from the partner
  logic [3:0]  ext, wstrb;                   // Cycle length, write strobes
  logic [11:0] awaddr, araddr;               // Bus addresses
  logic [31:0] wdata, rdata;                 // Bus data
  logic [1:0]  bresp, rresp;                 // Bus responses
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          err_total, cmp_count;         // Mismatch and check counters
  logic [1:0]  wresp;                        // Last write response
  int          tick_cnt = 0;                 // Processor tick pulses seen

  dual_timer_interrupt_unit u_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .hf_osc_i(hf), .lf_osc_i(lf),
    .port0_pins_i(p0), .port1_pins_i(p1), .reserved_evt_i(rsv), .pwm_period_done_i(pwm),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .irq_o(irq), .powered_down_out_o(powered_down_out), .cpu_tick_o(tick),
    .ext_cycle_clks_o(ext));
  pin_partner u_src (.clock_i(clock_i), .hf_osc_o(hf), .lf_osc_o(lf), .port0_o(p0), .port1_o(p1));
  // Count processor tick pulses; each stands one cycle so it is seen once
  always @(posedge clock_i) begin
    if (tick === 1'b1) tick_cnt <= tick_cnt + 1;
  end

  // Free-running 250 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // Counts, verdict and end of run; also reached from a stuck wait
  task automatic summarize();
    $display("checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // Bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    bit ok;
    ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge clock_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        ok = 1'b1;
        wresp = bresp;
        bready <= 1'b0;
      end
    end
    // One idle edge, so a following call never drives bready twice in one step
    if (!ok) begin
      err_total++;
      summarize();
    end else @(posedge clock_i);
  endtask
  // Bus read: data and response taken at the edge that sees rvalid
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ok;
    ok = 1'b0;
    d = 32'h0;
    r = 2'h0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge clock_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        ok = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    // One idle edge, so a following call never drives rready twice in one step
    if (!ok) begin
      err_total++;
      summarize();
    end else @(posedge clock_i);
  endtask
  // Expected count and overflow flag after n ticks from a reset counter
  function automatic logic [8:0] tmr_model(input byte_t rl, input int n);
    byte_t c;
    logic  o;
    c = 8'h00;
    o = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (c == `TMR_TOP) begin
        c = rl;
        o = 1'b1;
      end else c = c + 8'h01;
    end
    return {o, c};
  endfunction

  // Main sequence
  initial begin
    byte_t       rl, t1_cnt;
    int          n, k;
    logic [8:0]  m;
    logic [31:0] d;
    logic [1:0]  r;
    logic [4:0]  mk;
    logic [5:0]  cfg;
    logic [2:0]  dv;
    {arst_n_i, rsv, pwm, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    t1_cnt = 8'h00;
    void'($urandom(16239));
    wait_clk(12);
    arst_n_i <= 1'b1;
    wait_clk(1);
    `CHK(ext, 4'h2)
    `CHK(powered_down_out, 1'b0)
    rd(`OFF_CLK_CFG, d, r);
    `CHK(d, 32'h00000010)
    // Each timer: reload readback, masked strobe, count past overflow
    for (int t = 0; t < 2; t++) begin
      rl = byte_t'($urandom);
      wr(`OFF_T1_RELOAD + 12'(4 * t), {24'h0, rl}, 4'hf);
      `CHK(wresp, `RESP_OKAY)
      wr(`OFF_T1_RELOAD + 12'(4 * t), {24'h0, ~rl}, 4'h0);
      rd(`OFF_T1_RELOAD + 12'(4 * t), d, r);
      `CHK(d, {24'h0, rl})
      n = 256 + int'($urandom_range(40));
      u_src.osc_ticks(t, n);
      m = tmr_model(rl, n);
      rd(`OFF_T1_COUNT + 12'(4 * t), d, r);
      `CHK(d[7:0], m[7:0])
      rd(`OFF_IRQ_REQ, d, r);
      `CHK(d[1 + t], m[8])
      rd(`OFF_T1_COUNT, d, r);
      if (t == 0) t1_cnt = d[7:0];
      else `CHK(d[7:0], t1_cnt)
    end
    // Port 0 bit 0 edge: sticky request, mask gates the line
    wr(`OFF_IRQ_REQ, 32'h1f, 4'hf);
    wr(`OFF_IRQ_MASK, 32'h01, 4'hf);
    u_src.set_ports(8'h01, 8'h00);
    wait_clk(8);
    `CHK(irq, 1'b1)
    wr(`OFF_IRQ_MASK, 32'h0, 4'hf);
    wait_clk(2);
    `CHK(irq, 1'b0)
    rd(`OFF_IRQ_REQ, d, r);
    `CHK(d[4:0], 5'h01)
    wr(`OFF_IRQ_REQ, 32'h01, 4'hf);
    wait_clk(8);
    rd(`OFF_IRQ_REQ, d, r);
    `CHK(d[4:0], 5'h00)
    u_src.set_ports(8'h00, 8'h00);
    // Reserved and PWM events under a random mask
    mk = 5'($urandom);
    wr(`OFF_IRQ_MASK, {27'h0, mk}, 4'hf);
    for (int s = 3; s < 5; s++) begin
      if (s == 3) rsv <= 1'b1;
      else pwm <= 1'b1;
      wait_clk(1);
      rsv <= 1'b0;
      pwm <= 1'b0;
      wait_clk(2);
      `CHK(irq, mk[s])
      rd(`OFF_IRQ_REQ, d, r);
      `CHK(d[4:0], 5'(1 << s))
      wr(`OFF_IRQ_REQ, 32'h1f, 4'hf);
    end
    // Power-down and wake by a random port 1 pin
    wr(`OFF_PWR, 32'h1, 4'hf);
    wait_clk(2);
    `CHK(powered_down_out, 1'b1)
    u_src.set_ports(8'h00, 8'(1 << $urandom_range(7)));
    wait_clk(10);
    `CHK(powered_down_out, 1'b0)
    // Every wait-state setting with random source and divider
    for (int ws = 0; ws < 4; ws++) begin
      cfg = {2'(ws), 4'($urandom)};
      wr(`OFF_CLK_CFG, {26'h0, cfg}, 4'hf);
      wait_clk(2);
      `CHK(ext, 4'(1 + ws))
      rd(`OFF_CLK_CFG, d, r);
      `CHK(d[5:0], cfg)
    end
    // Processor tick per source: k pulses from k times (divider + 1) source edges
    for (int sc = 0; sc < 2; sc++) begin
      dv = 3'($urandom);
      k = 2 + int'($urandom_range(3));
      wr(`OFF_CLK_CFG, {26'h0, 2'h1, dv, 1'(sc)}, 4'hf);
      n = tick_cnt;
      u_src.osc_ticks(sc, k * (int'(dv) + 1));
      wait_clk(4);
      `CHK(tick_cnt - n, k)
    end
    // Powered down: the selected source runs but no tick; a port 0 pin wakes
    wr(`OFF_PWR, 32'h1, 4'hf);
    n = tick_cnt;
    u_src.osc_ticks(1, 4);
    `CHK(tick_cnt - n, 0)
    `CHK(powered_down_out, 1'b1)
    u_src.set_ports(8'h80, 8'h00);
    wait_clk(10);
    `CHK(powered_down_out, 1'b0)
    // Unmapped address is refused on both paths and stores nothing
    rd(12'h100, d, r);
    `CHK(r, `RESP_SLVERR)
    `CHK(d, 32'h0)
    wr(12'h100, 32'hff, 4'hf);
    `CHK(wresp, `RESP_SLVERR)
    summarize();
  end
endmodule
